// >>> rtl/ppm_params.svh
// constants for the port pin override multiplexer
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH
`define PPM_NPIN          4
`define PPM_AW            8
`define PPM_IDX_INPUT     6'h00
`define PPM_IDX_DIR       6'h01
`define PPM_IDX_DATA      6'h02
`define PPM_IDX_PULLUP    6'h03
`define PPM_RST_PORT      4'h0
`define PPM_RST_SYNC      4'h0
`define PPM_RST_RDATA     32'h0000_0000
`define PPM_PIN_CMPA      0
`define PPM_PIN_CMPB      1
`define PPM_PIN_CLKOUT    2
`define PPM_PIN_PROGDATA  0
`define PPM_PIN_PROGCLK   1
`define PPM_PIN_CAPTURE   1
`define PPM_PIN_EXTCLK    1
`define PPM_PIN_IRQ0      2
`define PPM_PIN_T0        2
`define PPM_PIN_CMP_POS   0
`define PPM_PIN_CMP_NEG   1
`endif

// >>> rtl/ppm_pkg.sv
// types for the port pin override multiplexer
`default_nettype none
package ppm_pkg;
	typedef struct packed {
		logic pullup_override_en;
		logic pullup_override_val;
		logic dir_override_en;
		logic dir_override_val;
		logic level_override_en;
		logic level_override_val;
		logic toggle_override_en;
		logic input_gate_override_en;
		logic input_gate_override_val;
	} ppm_ovr_s;
	typedef struct packed {
		logic [3:0] pad_out;
		logic [3:0] pad_oe;
		logic [3:0] pad_pullup;
		logic [3:0] input_gate;
	} ppm_pad_s;
	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} ppm_apb_req_s;
endpackage
`default_nettype wire

// >>> rtl/ppm_top.sv
// four-pin general purpose port with alternate-function override muxing
`include "ppm_params.svh"
`default_nettype none
module ppm_top #(
	parameter int NPIN = `PPM_NPIN
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	// apb slave
	input  wire ppm_pkg::ppm_apb_req_s apb_req,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	// shared controls
	input  wire logic                  sleep_clamp,
	input  wire logic                  clock_out_fuse,
	input  wire logic                  sys_clock_level,
	// per pin overrides from alternate modules
	input  wire ppm_pkg::ppm_ovr_s     pin_ovr [NPIN],
	// pad side
	input  wire logic [NPIN-1:0]       pad_in,
	output ppm_pkg::ppm_pad_s          pad,
	output logic [NPIN-1:0]            analog_pad_link,
	// taps to alternate modules
	output logic [NPIN-1:0]            alt_fn_raw_input,
	output logic [NPIN-1:0]            pin_change_src,
	output logic                       capture_trigger_in,
	output logic                       ext_clock_in,
	output logic                       ext_irq_zero,
	output logic                       timer_ext_count_src,
	output logic                       prog_serial_data,
	output logic                       prog_serial_clock,
	output logic                       comparator_pos_in,
	output logic                       comparator_neg_in
);
	import ppm_pkg::*;

	generate
		if (NPIN != 4) begin : g_bad_npin
			$error("ppm_top serves exactly four pins");
		end
		// the fixed alternate-function pin map must land inside the port
		if (`PPM_PIN_CLKOUT >= NPIN || `PPM_PIN_IRQ0 >= NPIN ||
			`PPM_PIN_CAPTURE >= NPIN || `PPM_PIN_PROGCLK >= NPIN ||
			`PPM_PIN_CMP_NEG >= NPIN) begin : g_bad_map
			$error("ppm_top pin map points past the port");
		end
	endgenerate

	// port, synchroniser and apb answer state
	logic [3:0]  dir_r;
	logic [3:0]  dir_nxt;
	logic [3:0]  data_r;
	logic [3:0]  data_nxt;
	logic [3:0]  pullup_r;
	logic [3:0]  pullup_nxt;
	logic [3:0]  sync1_r;
	logic [3:0]  sync1_nxt;
	logic [3:0]  sync2_r;
	logic [3:0]  sync2_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        pready_r;
	logic        pready_nxt;
	logic        pslverr_r;
	logic        pslverr_nxt;

	// combinational helpers
	logic        clkout_active;
	logic [3:0]  pullup_bit;
	logic [3:0]  direction_bit;
	logic [3:0]  out_data_bit;
	logic [3:0]  pin_input_bit;
	logic [3:0]  gate;
	logic [5:0]  idx;
	logic        addr_ok;
	logic        setup_ph;
	logic        access_ph;
	logic        wr_take;
	ppm_pad_s    pad_c;

	// per-pin mux results, one bit from each generate pass
	wire logic [NPIN-1:0] mux_out;
	wire logic [NPIN-1:0] mux_oe;
	wire logic [NPIN-1:0] mux_pullup;
	wire logic [NPIN-1:0] mux_gate;

	// register bits under the names the pin logic uses
	assign pullup_bit    = pullup_r;
	assign direction_bit = dir_r;
	assign out_data_bit  = data_r;
	assign pin_input_bit = sync2_r;
	assign clkout_active = ~clock_out_fuse;

	// per-pin override mux, no clocked stage in the pad path
	generate
		for (genvar i = 0; i < NPIN; i++) begin : g_pin
			ppm_ovr_s ovr_in;
			ppm_ovr_s ovr_eff;
			logic     pu_sel;
			logic     oe_sel;
			logic     out_sel;
			logic     gate_sel;

			// each alternate module drives its own override fields
			assign ovr_in = pin_ovr[i];

			// the programmed clock-out fuse (low) takes over pull-up, direction and level of pin 2; the input gate override still passes
			always_comb begin
				ovr_eff = ovr_in;
				if (i == `PPM_PIN_CLKOUT && clkout_active) begin
					ovr_eff.pullup_override_en  = 1'b1;
					ovr_eff.pullup_override_val = 1'b0;
					ovr_eff.dir_override_en     = 1'b1;
					ovr_eff.dir_override_val    = 1'b1;
					ovr_eff.level_override_en   = 1'b1;
					ovr_eff.level_override_val  = sys_clock_level;
				end
			end

			always_comb begin
				if (ovr_eff.pullup_override_en) begin
					pu_sel = ovr_eff.pullup_override_val;
				end else begin
					pu_sel = (pullup_bit[i] == 1'b1);
				end
				if (ovr_eff.dir_override_en) begin
					oe_sel = ovr_eff.dir_override_val;
				end else begin
					oe_sel = direction_bit[i];
				end
				// the pad value is held low while not driven
				out_sel = 1'b0;
				if (oe_sel && ovr_eff.level_override_en) begin
					out_sel = ovr_eff.level_override_val;
				end else if (oe_sel) begin
					out_sel = out_data_bit[i] ^
						ovr_eff.toggle_override_en;
				end
				if (ovr_eff.input_gate_override_en) begin
					gate_sel = ovr_eff.input_gate_override_val;
				end else begin
					gate_sel = ~sleep_clamp;
				end
			end

			assign mux_pullup[i] = pu_sel;
			assign mux_oe[i]     = oe_sel;
			assign mux_out[i]    = out_sel;
			assign mux_gate[i]   = gate_sel;
		end
	endgenerate

	assign pad_c = '{
		pad_out:    mux_out,
		pad_oe:     mux_oe,
		pad_pullup: mux_pullup,
		input_gate: mux_gate
	};
	assign pad  = pad_c;
	assign gate = pad_c.input_gate;

	// raw tap: clamped input before the synchroniser
	assign alt_fn_raw_input = pad_in & gate;

	// analog path: the pad itself, never gated
	assign analog_pad_link  = pad_in;

	// taps to the alternate-function modules, unsynchronised
	assign pin_change_src      = alt_fn_raw_input;
	assign capture_trigger_in  = alt_fn_raw_input[`PPM_PIN_CAPTURE];
	assign ext_clock_in        = alt_fn_raw_input[`PPM_PIN_EXTCLK];
	assign ext_irq_zero        = alt_fn_raw_input[`PPM_PIN_IRQ0];
	assign timer_ext_count_src = alt_fn_raw_input[`PPM_PIN_T0];
	assign prog_serial_data    = alt_fn_raw_input[`PPM_PIN_PROGDATA];
	assign prog_serial_clock   = alt_fn_raw_input[`PPM_PIN_PROGCLK];
	assign comparator_pos_in   = analog_pad_link[`PPM_PIN_CMP_POS];
	assign comparator_neg_in   = analog_pad_link[`PPM_PIN_CMP_NEG];

	// apb decode, one word per register index
	assign idx      = apb_req.paddr[7:2];
	always_comb begin
		addr_ok = 1'b0;
		if (apb_req.paddr[1:0] == 2'h0) begin
			case (idx)
				`PPM_IDX_INPUT:  addr_ok = 1'b1;
				`PPM_IDX_DIR:    addr_ok = 1'b1;
				`PPM_IDX_DATA:   addr_ok = 1'b1;
				`PPM_IDX_PULLUP: addr_ok = 1'b1;
				default:         addr_ok = 1'b0;
			endcase
		end
	end
	assign setup_ph  = apb_req.psel & ~apb_req.penable;
	assign access_ph = apb_req.psel & apb_req.penable & pready_r;
	assign wr_take   = access_ph & apb_req.pwrite & addr_ok;

	// port registers, one write strobe per register for all pins
	always_comb begin
		dir_nxt    = dir_r;
		data_nxt   = data_r;
		pullup_nxt = pullup_r;
		if (wr_take) begin
			case (idx)
				`PPM_IDX_DIR:    dir_nxt = apb_req.pwdata[3:0];
				`PPM_IDX_DATA:   data_nxt = apb_req.pwdata[3:0];
				`PPM_IDX_PULLUP: pullup_nxt = apb_req.pwdata[3:0];
				`PPM_IDX_INPUT:  data_nxt = data_r ^ apb_req.pwdata[3:0];
				default:         data_nxt = data_r;
			endcase
		end
	end

	// read path and single wait-free answer
	always_comb begin
		prdata_nxt  = prdata_r;
		pready_nxt  = setup_ph;
		pslverr_nxt = 1'b0;
		if (setup_ph) begin
			prdata_nxt  = `PPM_RST_RDATA;
			pslverr_nxt = ~addr_ok;
			if (!apb_req.pwrite) begin
				case (idx)
					`PPM_IDX_INPUT:  prdata_nxt[3:0] = pin_input_bit;
					`PPM_IDX_DIR:    prdata_nxt[3:0] = dir_r;
					`PPM_IDX_DATA:   prdata_nxt[3:0] = data_r;
					`PPM_IDX_PULLUP: prdata_nxt[3:0] = pullup_r;
					default:         prdata_nxt = `PPM_RST_RDATA;
				endcase
			end
		end
	end

	// port registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dir_r    <= `PPM_RST_PORT;
			data_r   <= `PPM_RST_PORT;
			pullup_r <= `PPM_RST_PORT;
		end else begin
			dir_r    <= dir_nxt;
			data_r   <= data_nxt;
			pullup_r <= pullup_nxt;
		end
	end

	// two-flop synchroniser on the gated pad, only stage two is read
	always_comb begin
		sync1_nxt = pad_in & gate;
		sync2_nxt = sync1_r;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= `PPM_RST_SYNC;
			sync2_r <= `PPM_RST_SYNC;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
		end
	end

	// apb answer registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prdata_r  <= `PPM_RST_RDATA;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// apb outputs straight from their flops
	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;
endmodule
`default_nettype wire

// >>> bench/ppm_top_properties.sv
// assertions on the pin override mux ports
`default_nettype none
module ppm_chk (
	// clock and reset
	input wire logic                  clk_sys,
	input wire logic                  rst_n,
	// apb and shared controls
	input wire ppm_pkg::ppm_apb_req_s apb_req,
	input wire logic                  pready,
	input wire logic                  sleep_clamp,
	input wire logic                  clock_out_fuse,
	input wire logic                  sys_clock_level,
	// overrides and pads
	input wire ppm_pkg::ppm_ovr_s     pin_ovr [4],
	input wire logic [3:0]            pad_in,
	input wire ppm_pkg::ppm_pad_s     pad,
	input wire logic [3:0]            analog_pad_link,
	input wire logic [3:0]            alt_fn_raw_input,
	input wire logic [3:0]            pin_change_src
);
	import ppm_pkg::*;
	ppm_ovr_s o;
	assign o = pin_ovr[0];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	chk_pullup_ovr: assert property (o.pullup_override_en |->
		pad.pad_pullup[0] == o.pullup_override_val) else $error("pull-up");
	chk_dir_ovr: assert property (o.dir_override_en |->
		pad.pad_oe[0] == o.dir_override_val) else $error("direction");
	chk_level_ovr: assert property (pad.pad_oe[0] && o.level_override_en
		|-> pad.pad_out[0] == o.level_override_val) else $error("level");
	chk_gate_sel: assert property (pad.input_gate[0] ==
		(o.input_gate_override_en ? o.input_gate_override_val : !sleep_clamp))
		else $error("input gate");
	chk_clock_out: assert property (!clock_out_fuse |-> pad.pad_oe[2] &&
		pad.pad_out[2] == sys_clock_level && !pad.pad_pullup[2])
		else $error("clock out");
	chk_raw_tap: assert property (alt_fn_raw_input == (pad_in &
		pad.input_gate) && pin_change_src == alt_fn_raw_input) else $error("tap");
	chk_analog_link: assert property (analog_pad_link == pad_in)
		else $error("analog");
	chk_apb_answer: assert property (apb_req.psel && !apb_req.penable
		|=> pready) else $error("no ready");
	cover property (pad.pad_oe[0] && o.level_override_en);
	cover property (!clock_out_fuse);
	cover property (pready && !apb_req.pwrite);
endmodule
`default_nettype wire

// >>> bench/ppm_alt_model.sv
// alternate-function side: makes the per-pin override signals
`default_nettype none
module ppm_alt_model (
	// timer compare waves for pins 0 and 1
	input wire logic [1:0]     wave_en,
	input wire logic [1:0]     wave,
	// other override fields, nine a pin
	input wire logic [35:0]    other,
	// to the port
	output ppm_pkg::ppm_ovr_s  pin_ovr [4]
);
	always_comb begin
		for (int i = 0; i < 4; i++)
			pin_ovr[i] = other[i*9 +: 9];
		for (int i = 0; i < 2; i++) begin
			pin_ovr[i].level_override_en = wave_en[i];
			pin_ovr[i].level_override_val = wave[i];
		end
	end
endmodule
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the pin override mux
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ppm_pkg::*;
	logic clk_sys, rst_n, slp, fuse, sclk, pready, pslverr;
	logic [1:0] wen, wv;
	logic [35:0] oth;
	logic [3:0] pin, d, q, pu, alink, raw, pcs;
	wire [7:0] tp;
	logic [31:0] prdata;
	logic [32:0] nq [$];
	ppm_apb_req_s req;
	ppm_ovr_s ov [4];
	ppm_pad_s pad;
	int bad_count = 0, n_compared = 0, cyc = 0;
	ppm_alt_model i_alt (.wave_en(wen), .wave(wv), .other(oth), .pin_ovr(ov));
	ppm_top i_dut (.clk_sys, .rst_n, .apb_req(req), .prdata, .pready,
		.pslverr, .sleep_clamp(slp), .clock_out_fuse(fuse),
		.sys_clock_level(sclk), .pin_ovr(ov), .pad_in(pin), .pad,
		.analog_pad_link(alink), .alt_fn_raw_input(raw),
		.pin_change_src(pcs), .capture_trigger_in(tp[5]),
		.ext_clock_in(tp[4]), .ext_irq_zero(tp[3]),
		.timer_ext_count_src(tp[2]), .prog_serial_data(tp[1]),
		.prog_serial_clock(tp[0]), .comparator_pos_in(tp[6]),
		.comparator_neg_in(tp[7]));
	initial begin
		clk_sys = 0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic bad(input string m);
		bad_count++;
		$display("FAIL %0t %s", $time, m);
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] x);
		@(posedge clk_sys) req <= '{1'b1, 1'b0, w, a, x};
		@(posedge clk_sys) req.penable <= 1'b1;
		// pready is read at the rising edge, before the design updates it
		do @(posedge clk_sys); while (pready !== 1'b1);
		req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		nq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic chk_pad();
		ppm_pad_s e;
		ppm_ovr_s o;
		logic [3:0] r;
		@(negedge clk_sys);
		for (int i = 0; i < 4; i++) begin
			o = ov[i];
			e.pad_pullup[i] = o.pullup_override_en ? o.pullup_override_val : pu[i];
			e.pad_oe[i] = o.dir_override_en ? o.dir_override_val : d[i];
			e.pad_out[i] = e.pad_oe[i] & (o.level_override_en ?
				o.level_override_val : q[i] ^ o.toggle_override_en);
			e.input_gate[i] = o.input_gate_override_en ?
				o.input_gate_override_val : !slp;
		end
		if (!fuse) begin
			e.pad_pullup[2] = 1'b0;
			e.pad_oe[2] = 1'b1;
			e.pad_out[2] = sclk;
		end
		r = pin & e.input_gate;
		n_compared += 2;
		if (pad !== e) bad("pad");
		if ({raw, pcs, alink, tp} !== {r, r, pin, pin[1:0], r[1], r[1], r[2],
			r[2], r[0], r[1]}) bad("taps");
	endtask
	always @(posedge clk_sys)
		if (req.psel && req.penable && pready === 1'b1 && !req.pwrite) begin
			n_compared++;
			if (nq.size() == 0 || {pslverr, prdata} !== nq.pop_front())
				bad("read data");
		end
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial begin
		{rst_n, req, slp, sclk, wen, wv, oth, pin, d, q, pu} = '0;
		fuse = 1'b1;
		void'($urandom(32'h66CDF9FB));
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(8'h04, 33'h0);
		rd(8'h08, 33'h0);
		rd(8'h0C, 33'h0);
		rd(8'h10, 33'h100000000);
		rd(8'h05, 33'h100000000);
		$display("test reset and decode done");
		repeat (30) begin
			{d, q, pu} = 12'($urandom);
			apb(1'b1, 8'h04, {28'h0, d});
			apb(1'b1, 8'h08, {28'h0, q});
			apb(1'b1, 8'h0C, {28'h0, pu});
			@(posedge clk_sys) begin
				oth <= {4'($urandom), $urandom};
				{wen, wv, pin, slp, fuse, sclk} <= 11'($urandom);
			end
			chk_pad();
		end
		$display("test override mix done");
		pu = 4'h0;
		d = 4'h3;
		apb(1'b1, 8'h0C, 32'h0);
		apb(1'b1, 8'h04, {28'h0, d});
		@(posedge clk_sys) begin
			{oth, fuse} <= {36'h0, 1'b1};
			{wen, wv, pin} <= {2'h3, 6'($urandom)};
		end
		chk_pad();
		d = 4'h0;
		apb(1'b1, 8'h04, 32'h0);
		@(posedge clk_sys) {wen, pin} <= {2'h0, 4'($urandom)};
		chk_pad();
		$display("test compare waves and comparator inputs done");
		@(posedge clk_sys) {oth, wen, slp} <= '0;
		apb(1'b1, 8'h00, 32'h5);
		q ^= 4'h5;
		repeat (4) @(posedge clk_sys);
		rd(8'h08, {29'h0, q});
		rd(8'h00, {29'h0, pin});
		repeat (2) @(posedge clk_sys);
		$display("test toggle and input read done");
		tally_and_finish();
	end
endmodule
bind ppm_top ppm_chk i_chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .apb_req(apb_req), .pready(pready),
	.sleep_clamp(sleep_clamp), .clock_out_fuse(clock_out_fuse),
	.sys_clock_level(sys_clock_level), .pin_ovr(pin_ovr),
	.pad_in(pad_in), .pad(pad), .analog_pad_link(analog_pad_link),
	.alt_fn_raw_input(alt_fn_raw_input), .pin_change_src(pin_change_src));
`default_nettype wire
